// ===== src/dr5_register.sv
// Five-bit edge-triggered register with differential data, clock and outputs.
// Assumes pins are asynchronous to ref_clk and each level holds >= 3 ref_clk cycles.
// Outputs come straight from flops; clear and rst_n share one release chain.
`timescale 1ns/1ps
`default_nettype none

module dr5_register (
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    input  wire logic              async_clear_in,
    input  wire dr5_pkg::dr5_bus_t data_in,
    input  wire dr5_pkg::dr5_clk_t clk_pair_in,
    output var  dr5_pkg::dr5_bus_t data_out
);
    import dr5_pkg::*;

    // ***************************************************************
    // Pair decoding
    // ***************************************************************
    // Equal sides count as open; the clamp then asserts the inverted side
    function automatic logic [DR5_WIDTH-1:0] pair_level(
        input logic [DR5_WIDTH-1:0] p,
        input logic [DR5_WIDTH-1:0] n
    );
        pair_level = p & ~n;
    endfunction

    // Single-pair form for the clock; avoids selecting from a call result
    function automatic logic pair_one(
        input logic p,
        input logic n
    );
        pair_one = p & ~n;
    endfunction

    // ***************************************************************
    // Reset and clear chain
    // ***************************************************************
    logic       clr_any;
    logic [1:0] chain_reg;
    logic       core_rst_n;

    // Clear and reset assert at once, release through two flops
    assign clr_any = async_clear_in | ~rst_n;

    always_ff @(posedge ref_clk or posedge clr_any) begin
        if (clr_any) begin
            chain_reg <= DR5_CHAIN_RST;
        end else begin
            chain_reg <= {chain_reg[0], 1'b1};
        end
    end

    // Release is synchronous so the core never sees reset drop near a clock edge
    // Limitation: even a short clear costs two edges before loads resume
    assign core_rst_n = chain_reg[1];

    // ***************************************************************
    // Core state
    // ***************************************************************
    dr5_state_t           st_reg;
    dr5_state_t           st_next;
    logic                 clk_lvl;
    logic                 clk_rise;
    logic [DR5_WIDTH-1:0] d_lvl;
    logic [DR5_WIDTH-1:0] open_mask;
    logic [DR5_WIDTH-1:0] d_true;

    // Decode only the second sync stage; the first may still be settling
    assign clk_lvl  = pair_one(st_reg.sync2.c.p, st_reg.sync2.c.n);
    assign d_lvl    = pair_level(st_reg.sync2.d.p, st_reg.sync2.d.n);
    assign clk_rise = clk_lvl & ~st_reg.clk_prev;

    // Next state: sync pipeline, edge detect, per-bit capture
    always_comb begin
        st_next          = st_reg;
        // Pins enter the first stage only; every decoder reads the second
        st_next.sync1.d  = data_in;
        st_next.sync1.c  = clk_pair_in;
        st_next.sync2    = st_reg.sync1;
        st_next.clk_prev = clk_lvl;
        if (clk_rise) begin
            // Each bit takes only its own pair, so open bits touch no neighbour
            st_next.q  = d_lvl;
            st_next.qn = ~d_lvl;
        end
    end

    // Clear gives q low and qn high together
    always_ff @(posedge ref_clk or negedge core_rst_n) begin
        if (!core_rst_n) begin
            st_reg          <= '0;
            st_reg.clk_prev <= DR5_CLK_PRESET;
            // Clock syncs also rest high, so a pin already high is no edge at release
            st_reg.sync1.c  <= '{p: DR5_CLK_PRESET, n: ~DR5_CLK_PRESET};
            st_reg.sync2.c  <= '{p: DR5_CLK_PRESET, n: ~DR5_CLK_PRESET};
            st_reg.q        <= DR5_Q_RESET;
            st_reg.qn       <= DR5_QN_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    // One assignment keeps a single driver on the output struct
    assign data_out = '{p: st_reg.q, n: st_reg.qn};

    // ***************************************************************
    // Check helpers
    // ***************************************************************
    // Which pairs were open at the edge, and their true sides, for the checks
    assign open_mask = ~(st_reg.sync2.d.p ^ st_reg.sync2.d.n);
    assign d_true    = st_reg.sync2.d.p;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!core_rst_n);

    sequence rise_seen;
        clk_rise;
    endsequence

    // The value decoded at the edge is compared one cycle on, once stored
    sequence loaded_next;
        ##1 (data_out.p == $past(d_lvl));
    endsequence

    bit_load_a: assert property (rise_seen |-> loaded_next)
        else $error("bits did not load on clock rise");

    bit_hold_a: assert property (!clk_rise |=> $stable(data_out.p))
        else $error("bits changed without clock rise");

    clear_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        async_clear_in |-> (data_out.p == DR5_Q_RESET))
        else $error("clear did not zero the bits");

    // Any pair open at the edge must store zero
    sequence open_at_rise;
        clk_rise && (open_mask != '0);
    endsequence

    open_data_a: assert property (
        open_at_rise |=> ((data_out.p & $past(open_mask)) == '0))
        else $error("open data pair did not read zero");

    // Driven pairs still store their true side while others are open
    open_neighbour_a: assert property (
        open_at_rise
        |=> ((data_out.p & ~$past(open_mask)) == ($past(d_true) & ~$past(open_mask))))
        else $error("open pair disturbed other bits");

    clk_open_a: assert property (
        (st_reg.sync2.c.p == st_reg.sync2.c.n) |=> $stable(data_out.p))
        else $error("open clock pair changed the bits");

    pair_comp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        data_out.n == ~data_out.p)
        else $error("output pair not complementary");

    // A pin clock rise held for two more samples reaches the detector then
    sequence pin_rise_held;
        $rose(clk_pair_in.p & ~clk_pair_in.n) ##1 (clk_pair_in.p & ~clk_pair_in.n) [*2];
    endsequence

    sync_delay_a: assert property (pin_rise_held |-> clk_rise)
        else $error("clock rise not seen two cycles later");

    // No edge in the first cycles after release, whatever the pin level
    release_quiet_a: assert property ($rose(core_rst_n) |-> !clk_rise [*3])
        else $error("false clock edge after release");

    // The inverted side takes the complement of the loaded value
    load_inv_a: assert property (rise_seen |=> (data_out.n == ~$past(d_lvl)))
        else $error("inverted side did not load on clock rise");

    // The stored value also holds on the inverted side between edges
    pair_hold_a: assert property (!clk_rise |=> $stable(data_out.n))
        else $error("inverted side changed without clock rise");

    // An open clock pair rests low, so the next level seen is low
    clk_rest_a: assert property (
        (st_reg.sync2.c.p == st_reg.sync2.c.n) |=> !st_reg.clk_prev)
        else $error("open clock pair did not rest low");

    // While clear stands, the inverted side reads all ones
    clear_ones_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        async_clear_in |-> (data_out.n == DR5_QN_RESET))
        else $error("clear did not set the inverted side");

    // Clear holds the bits still even across clock pin activity
    clear_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        async_clear_in |=> $stable(data_out.p))
        else $error("bits moved while clear was high");

    // After clear drops, the bits stay zero until the chain has released
    clear_release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(async_clear_in) |-> (data_out.p == DR5_Q_RESET) [*2])
        else $error("bits loaded before release completed");

    // Release needs two clean edges: the first stage, then the core
    release_step_a: assert property (@(posedge ref_clk) disable iff (clr_any)
        chain_reg[0] |=> (chain_reg == DR5_CHAIN_DONE))
        else $error("release chain did not complete");

    // The core stays held for one more edge after the first stage sets
    release_delay_a: assert property (@(posedge ref_clk) disable iff (clr_any)
        !chain_reg[0] |=> !core_rst_n)
        else $error("core released after a single edge");

endmodule

`default_nettype wire

// ===== src/dr5_pkg.sv
// Constants and carrier types for the five-bit differential register.
// Assumes a single 100 MHz ref_clk domain; every pin pair is asynchronous to it.
package dr5_pkg;

    // ***************************************************************
    // Widths and reset values
    // ***************************************************************
    localparam int          DR5_WIDTH      = 5;
    localparam logic [4:0]  DR5_Q_RESET    = 5'h00;
    localparam logic [4:0]  DR5_QN_RESET   = 5'h1f;
    localparam logic        DR5_CLK_PRESET = 1'h1;  // Blocks a false edge after release
    localparam logic [1:0]  DR5_CHAIN_RST  = 2'h0;
    localparam logic [1:0]  DR5_CHAIN_DONE = 2'h3;

    // ***************************************************************
    // Carrier types
    // ***************************************************************
    // One differential bus: true and inverted sides
    typedef struct packed {
        logic [DR5_WIDTH-1:0] p;
        logic [DR5_WIDTH-1:0] n;
    } dr5_bus_t;

    // Differential clock pair
    typedef struct packed {
        logic p;
        logic n;
    } dr5_clk_t;

    // Whole synchronised pin image
    typedef struct packed {
        dr5_bus_t d;
        dr5_clk_t c;
    } dr5_pins_t;

    // Module state apart from the release chain
    typedef struct packed {
        dr5_pins_t            sync1;
        dr5_pins_t            sync2;
        logic                 clk_prev;
        logic [DR5_WIDTH-1:0] q;
        logic [DR5_WIDTH-1:0] qn;
    } dr5_state_t;

endpackage

// ===== verif/dr5_upstream.sv
// Upstream logic model that drives the register's data and clock pairs.
// Assumes ref_clk at 100 MHz; every pin change lands just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module dr5_upstream (
    input  wire logic              ref_clk,
    output var  dr5_pkg::dr5_bus_t d_pins,
    output var  dr5_pkg::dr5_clk_t c_pins
);
    import dr5_pkg::*;
    // Clock pair rests low; data starts at zero
    initial begin
        d_pins = '0;
        c_pins = 2'h1;
    end
    // One clocked transfer; open pairs sit in the clamped both-low state
    task automatic send(input logic [4:0] v, input logic [4:0] om, input logic oc);
        d_pins <= '{p: v & ~om, n: ~v & ~om};
        repeat (3) @(posedge ref_clk);
        c_pins <= oc ? 2'h0 : 2'h2;
        @(posedge ref_clk);
        // Hold is over: flip the data so a late sample shows up
        d_pins <= '{p: ~v & ~om, n: v & ~om};
        repeat (2) @(posedge ref_clk);
        c_pins <= 2'h1;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire

// ===== verif/dr5_register_tb.sv
// Self-checking bench for the five-bit differential register.
// Assumes dr5_upstream drives the pins; expectations come from the rules.
`timescale 1ns/1ps
`default_nettype none
module dr5_register_tb;
    import dr5_pkg::*;
    logic     ref_clk   = 1'h0;
    logic     rst_n     = 1'h0;
    logic     clr       = 1'h0;
    dr5_bus_t din;
    dr5_clk_t cin;
    dr5_bus_t dout;
    int       bad_count = 0;
    int       n_checks  = 0;
    int       cyc       = 0;
    always #5 ref_clk = ~ref_clk;
    dr5_upstream UP (.ref_clk(ref_clk), .d_pins(din), .c_pins(cin));
    dr5_register DUT (.ref_clk(ref_clk), .rst_n(rst_n), .async_clear_in(clr),
                      .data_in(din), .clk_pair_in(cin), .data_out(dout));
    // Both sides of the output pair
    task automatic chk(input logic [4:0] e);
        n_checks++;
        if (dout !== {e, ~e}) begin
            bad_count++;
            $display("[FAIL] %0t out %h exp %h", $time, dout, e);
        end
    endtask
    task automatic test_done();
        if (bad_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Back-to-back loads with every bit flipping
    task automatic t_load();
        UP.send(5'h15, 5'h00, 1'h0);
        chk(5'h15);
        UP.send(5'h0a, 5'h00, 1'h0);
        chk(5'h0a);
    endtask
    // Open pairs read zero, neighbours still load
    task automatic t_open();
        UP.send(5'h1f, 5'h0a, 1'h0);
        chk(5'h15);
    endtask
    // Open clock and data together: no edge, old value kept
    task automatic t_noclk();
        UP.send(5'h0a, 5'h1f, 1'h1);
        chk(5'h15);
    endtask
    // Clear acts before the next edge and blocks loads while high
    task automatic t_clear();
        clr <= 1'h1;
        @(negedge ref_clk);
        chk(5'h00);
        @(posedge ref_clk);
        UP.send(5'h1f, 5'h00, 1'h0);
        chk(5'h00);
        clr <= 1'h0;
        repeat (4) @(posedge ref_clk);
        UP.send(5'h11, 5'h00, 1'h0);
        chk(5'h11);
    endtask
    // Hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
        t_load();
        t_open();
        t_noclk();
        t_clear();
        test_done();
    end
endmodule
`default_nettype wire
